// File: rtl/cmpm_ctrl.sv
// Chip mode and power mode controller: strap capture, debug enables,
// boot selection, run/wait/pseudo-stop/stop sequencing, clock gates.
// Assumes the core, debug unit and peripherals honour the enables.
//
// What this block does
// - Capture mode strap when external reset releases.
// - Strap 1 normal, strap 0 special mode.
// - Mode bit readable; only special-to-normal writes allowed.
// - Normal mode boots from programmed reset vector.
// - Special mode: debug unit active, ROM monitor.
// - Debug enable depends on mode and security.
// - Chosen modules freeze while debug unit active.
// - Run clocks all; software picks source, PLL.
// - Wait instruction gates core clock, enters wait.
// - In wait, each peripheral may gate itself.
// - Wait ends on reset, NMI, IRQ, unmasked interrupt.
// - Pseudo-stop: oscillator on, four sources may run.
// - Stop: oscillator off, counters and dividers frozen.
// - Stop wakes only by reset, timer, converter, key, LIN.
// - Secure state blocks debug access to flash.
`timescale 1ns/1ns
module cmpm_ctrl
  import cmpm_pkg::*;
(
  // Clock and external reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  arst_n_in,
  // Strap and security
  input  wire logic                  mode_select_strap_in,
  input  wire logic                  secure_in,
  // Software mode write
  input  wire logic                  mode_wr_in,
  input  wire logic                  mode_wdata_in,
  // Software clock configuration
  input  wire logic                  clk_cfg_wr_in,
  input  wire logic                  clk_src_sel_in,
  input  wire logic [PLL_MULT_W-1:0] pll_mult_in,
  // Core power requests
  input  wire logic                  wait_instruction_in,
  input  wire logic                  stop_instruction_in,
  input  wire logic                  pstop_sel_in,
  // Wake sources
  input  wire logic                  nonmaskable_int_request_in,
  input  wire logic                  ext_irq_in,
  input  wire logic                  int_unmasked_in,
  input  wire logic [NUM_SRC-1:0]    ps_evt_in,
  input  wire logic [NUM_SRC-1:0]    ps_en_in,
  input  wire logic [NUM_SRC-1:0]    st_evt_in,
  input  wire logic [NUM_SRC-1:0]    st_en_in,
  // Peripheral controls
  input  wire logic [NUM_PERIPH-1:0] periph_wait_gate_in,
  input  wire logic [NUM_FRZ-1:0]    freeze_en_in,
  // Mode status
  output logic                       mode_normal_out,
  output logic                       mode_wr_refused_out,
  output logic                       cpu_start_out,
  output logic                       boot_from_rom_out,
  output logic [15:0]                fetch_vector_out,
  output logic                       background_debug_unit_active_out,
  output logic                       debug_enable_out,
  output logic                       flash_dbg_block_out,
  output logic [NUM_FRZ-1:0]         freeze_out,
  // Clock configuration
  output logic                       clk_src_sel_out,
  output logic [PLL_MULT_W-1:0]      pll_mult_out,
  // Power state and clock gates
  output logic [1:0]                 pwr_state_out,
  output logic                       cpu_clk_en_out,
  output logic                       sys_clk_en_out,
  output logic                       osc_en_out,
  output logic                       counters_frozen_out,
  output logic [NUM_PERIPH-1:0]      periph_clk_en_out,
  output logic [NUM_SRC-1:0]         ps_clk_en_out,
  output logic [NUM_SRC-1:0]         st_src_live_out
);

  // ****************************************************************
  // Operating mode
  // ****************************************************************
  logic cap_done_reg;
  logic mode_reg;
  logic mode_next;
  logic wr_ok;
  logic refused_reg;
  logic dbg_act_reg;
  logic start_reg;
  logic rom_reg;
  logic [15:0] vec_reg;
  logic dbg_en_reg;
  logic flash_blk_reg;
  logic [NUM_FRZ-1:0] frz_reg;

  // A software write may only leave special mode; returning to special
  // would reopen debug access on a running part.
  assign wr_ok = cap_done_reg && mode_wr_in &&
                 mode_reg == MODE_SPECIAL &&
                 mode_wdata_in == MODE_NORMAL;

  // The strap is taken on the first edge after the reset releases,
  // because the reset itself may only load constants.
  assign mode_next = !cap_done_reg ? mode_select_strap_in :
                     wr_ok         ? MODE_NORMAL : mode_reg;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cap_done_reg <= 1'b0;
      mode_reg     <= MODE_RESET_VAL;
      refused_reg  <= 1'b0;
    end else begin
      cap_done_reg <= 1'b1;
      mode_reg     <= mode_next;
      refused_reg  <= cap_done_reg && mode_wr_in && !wr_ok;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dbg_act_reg   <= 1'b0;
      start_reg     <= 1'b0;
      rom_reg       <= 1'b0;
      vec_reg       <= RESET_VEC_ADDR;
      dbg_en_reg    <= 1'b0;
      flash_blk_reg <= 1'b1;
      frz_reg       <= '0;
    end else begin
      dbg_act_reg   <= (mode_next == MODE_SPECIAL);
      start_reg     <= cap_done_reg;
      rom_reg       <= (mode_next == MODE_SPECIAL);
      vec_reg       <= (mode_next == MODE_NORMAL) ? RESET_VEC_ADDR
                                                  : MON_ROM_ENTRY;
      dbg_en_reg    <= (mode_next == MODE_SPECIAL) | !secure_in;
      flash_blk_reg <= secure_in;
      frz_reg       <= freeze_en_in & {NUM_FRZ{dbg_act_reg}};
    end
  end

  // ****************************************************************
  // Clock configuration
  // ****************************************************************
  cmpm_pwr_e pwr_reg;
  logic clk_src_reg;
  logic [PLL_MULT_W-1:0] pll_reg;

  // Changes are taken only in run, so no clock switches while gated.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_src_reg <= CLK_SRC_RST;
      pll_reg     <= PLL_MULT_RST;
    end else if (clk_cfg_wr_in && pwr_reg == PM_RUN) begin
      clk_src_reg <= clk_src_sel_in;
      pll_reg     <= pll_mult_in;
    end
  end

  // ****************************************************************
  // Power mode sequencer
  // ****************************************************************
  cmpm_pwr_e pwr_next;
  logic      wake;
  logic      run_n;
  logic      dyn_n;

  cmpm_wake u_wake (
    .clk_sys_in      (clk_sys_in),
    .arst_n_in       (arst_n_in),
    .pwr_state_in    (pwr_reg),
    .nmi_req_in      (nonmaskable_int_request_in),
    .ext_irq_in      (ext_irq_in),
    .int_unmasked_in (int_unmasked_in),
    .ps_evt_in       (ps_evt_in),
    .ps_en_in        (ps_en_in),
    .st_evt_in       (st_evt_in),
    .st_en_in        (st_en_in),
    .wake_out        (wake)
  );

  // Wait takes priority over stop if the core raises both at once.
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      PM_RUN: begin
        if (wait_instruction_in) begin
          pwr_next = PM_WAIT;
        end else if (stop_instruction_in) begin
          pwr_next = pstop_sel_in ? PM_PSTOP : PM_STOP;
        end
      end
      PM_WAIT, PM_PSTOP, PM_STOP: begin
        if (wake) begin
          pwr_next = PM_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pwr_reg <= PM_RUN;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // ****************************************************************
  // Clock gates, derived from the next mode to line up with it
  // ****************************************************************
  logic                  cpu_clk_reg;
  logic                  sys_clk_reg;
  logic                  osc_reg;
  logic                  frozen_reg;
  logic [NUM_PERIPH-1:0] per_clk_reg;
  logic [NUM_SRC-1:0]    ps_clk_reg;
  logic [NUM_SRC-1:0]    st_live_reg;

  assign run_n = (pwr_next == PM_RUN);
  assign dyn_n = run_n | (pwr_next == PM_WAIT);

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cpu_clk_reg <= 1'b1;
      sys_clk_reg <= 1'b1;
      osc_reg     <= 1'b1;
      frozen_reg  <= 1'b0;
      per_clk_reg <= '1;
      ps_clk_reg  <= '1;
      st_live_reg <= '1;
    end else begin
      cpu_clk_reg <= run_n;
      sys_clk_reg <= dyn_n;
      osc_reg     <= (pwr_next != PM_STOP);
      frozen_reg  <= (pwr_next == PM_STOP);
      per_clk_reg <= {NUM_PERIPH{run_n}} |
                     ({NUM_PERIPH{pwr_next == PM_WAIT}} &
                      ~periph_wait_gate_in);
      ps_clk_reg  <= {NUM_SRC{dyn_n}} |
                     ({NUM_SRC{pwr_next == PM_PSTOP}} & ps_en_in);
      st_live_reg <= {NUM_SRC{pwr_next != PM_STOP}} | st_en_in;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign mode_normal_out                  = mode_reg;
  assign mode_wr_refused_out              = refused_reg;
  assign cpu_start_out                    = start_reg;
  assign boot_from_rom_out                = rom_reg;
  assign fetch_vector_out                 = vec_reg;
  assign background_debug_unit_active_out = dbg_act_reg;
  assign debug_enable_out                 = dbg_en_reg;
  assign flash_dbg_block_out              = flash_blk_reg;
  assign freeze_out                       = frz_reg;
  assign clk_src_sel_out                  = clk_src_reg;
  assign pll_mult_out                     = pll_reg;
  assign pwr_state_out                    = pwr_reg;
  assign cpu_clk_en_out                   = cpu_clk_reg;
  assign sys_clk_en_out                   = sys_clk_reg;
  assign osc_en_out                       = osc_reg;
  assign counters_frozen_out              = frozen_reg;
  assign periph_clk_en_out                = per_clk_reg;
  assign ps_clk_en_out                    = ps_clk_reg;
  assign st_src_live_out                  = st_live_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  a_strap_capture: assert property (
    $rose(cap_done_reg) |-> mode_reg == $past(mode_select_strap_in))
    else $error("mode bit does not hold the strap level");
  a_mode_no_demote: assert property (
    cap_done_reg && mode_reg == MODE_NORMAL |=> mode_reg == MODE_NORMAL)
    else $error("mode left normal after reset");
  a_mode_debug_unit: assert property (
    cap_done_reg |-> dbg_act_reg == (mode_reg == MODE_SPECIAL) &&
                     rom_reg == dbg_act_reg)
    else $error("debug unit state disagrees with mode");
  a_normal_vector: assert property (
    cap_done_reg && mode_reg == MODE_NORMAL |->
      vec_reg == RESET_VEC_ADDR)
    else $error("normal mode not booting from reset vector");
  a_debug_secure: assert property (
    $past(secure_in) && mode_reg == MODE_NORMAL &&
    $past(mode_reg) == MODE_NORMAL |-> !dbg_en_reg)
    else $error("debug enabled in secure normal mode");
  a_wait_entry: assert property (
    pwr_reg == PM_RUN && wait_instruction_in |=>
      pwr_reg == PM_WAIT && !cpu_clk_reg)
    else $error("wait instruction did not gate the core");
  a_wait_wake: assert property (
    pwr_reg == PM_WAIT && nonmaskable_int_request_in |->
      ##2 pwr_reg == PM_RUN)
    else $error("wait not ended by nmi");
  a_pstop_clocks: assert property (
    pwr_reg == PM_PSTOP |-> osc_reg && !sys_clk_reg)
    else $error("pseudo-stop clock gates wrong");
  a_stop_frozen: assert property (
    pwr_reg == PM_STOP |-> frozen_reg && !osc_reg && !cpu_clk_reg)
    else $error("stop mode not frozen");
  a_stop_wake: assert property (
    pwr_reg == PM_STOP && |(st_evt_in & st_en_in) |->
      ##2 pwr_reg == PM_RUN)
    else $error("enabled stop source did not wake");
  a_wait_gates: assert property (
    pwr_reg == PM_WAIT |-> per_clk_reg == ~$past(periph_wait_gate_in))
    else $error("peripheral wait gate not honoured");

  c_wait_cycle: cover property (
    pwr_reg == PM_WAIT ##[1:20] pwr_reg == PM_RUN);
  c_stop_cycle: cover property (
    pwr_reg == PM_STOP ##[1:20] pwr_reg == PM_RUN);
  c_pstop_cycle: cover property (
    pwr_reg == PM_PSTOP ##[1:20] pwr_reg == PM_RUN);
  c_mode_switch: cover property (
    mode_reg == MODE_SPECIAL ##1 mode_reg == MODE_NORMAL);

endmodule

// File: rtl/cmpm_pkg.sv
// Constants and types shared by the chip mode and power mode controller.
// Assumes a single system clock and an active low external reset.
package cmpm_pkg;

  // ****************************************************************
  // Power modes and chip modes
  // ****************************************************************
  typedef enum logic [1:0] {
    PM_RUN   = 2'b00,
    PM_WAIT  = 2'b01,
    PM_PSTOP = 2'b10,
    PM_STOP  = 2'b11
  } cmpm_pwr_e;

  localparam logic MODE_NORMAL    = 1'b1;
  localparam logic MODE_SPECIAL   = 1'b0;
  localparam logic MODE_RESET_VAL = 1'b1;

  // ****************************************************************
  // Boot addresses
  // ****************************************************************
  localparam logic [15:0] RESET_VEC_ADDR = 16'hFFFE;
  // Monitor entry point in the on-chip ROM; the value is arbitrary.
  localparam logic [15:0] MON_ROM_ENTRY  = 16'hF000;

  // ****************************************************************
  // Widths, indices and reset values
  // ****************************************************************
  localparam int          NUM_PERIPH      = 8;
  localparam int          NUM_FRZ         = 4;
  localparam int          NUM_SRC         = 4;
  localparam int          PLL_MULT_W      = 6;
  localparam logic        CLK_SRC_RST     = 1'b0;
  localparam logic [5:0]  PLL_MULT_RST    = 6'h01;
  // Pseudo-stop sources: tick, watchdog, periodic timer, converter.
  localparam int          PS_TICK         = 0;
  localparam int          PS_WDT          = 1;
  localparam int          PS_PWT          = 2;
  localparam int          PS_ADC          = 3;
  // Stop sources: periodic timer, converter, key wake-up, LIN phy.
  localparam int          ST_PWT          = 0;
  localparam int          ST_ADC          = 1;
  localparam int          ST_KEY          = 2;
  localparam int          ST_LIN          = 3;

endpackage

// File: rtl/cmpm_wake.sv
// Wake qualifier: decides which events end the current low-power mode.
// Assumes event inputs are synchronous levels or pulses on clk_sys_in.
`timescale 1ns/1ns
module cmpm_wake
  import cmpm_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 arst_n_in,
  // Current power mode
  input  wire logic [1:0]           pwr_state_in,
  // Wait mode sources
  input  wire logic                 nmi_req_in,
  input  wire logic                 ext_irq_in,
  input  wire logic                 int_unmasked_in,
  // Pseudo-stop and stop sources with their enables
  input  wire logic [NUM_SRC-1:0]   ps_evt_in,
  input  wire logic [NUM_SRC-1:0]   ps_en_in,
  input  wire logic [NUM_SRC-1:0]   st_evt_in,
  input  wire logic [NUM_SRC-1:0]   st_en_in,
  // Registered wake request
  output logic                      wake_out
);

  // ****************************************************************
  // Qualification
  // ****************************************************************
  logic wait_wake;
  logic ps_wake;
  logic st_wake;
  logic wake_next;
  logic wake_reg;

  assign wait_wake = nmi_req_in | ext_irq_in | int_unmasked_in;
  assign ps_wake   = |(ps_evt_in & ps_en_in);
  assign st_wake   = |(st_evt_in & st_en_in);
  assign wake_next = (pwr_state_in == PM_WAIT  && wait_wake) |
                     (pwr_state_in == PM_PSTOP && ps_wake) |
                     (pwr_state_in == PM_STOP  && st_wake);

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wake_next;
    end
  end

  assign wake_out = wake_reg;

endmodule

// File: testbench/chip_mode_power_mode_control_tb_top.sv
// Testbench for the chip mode and power mode controller.
// Assumes cmpm_pkg, cmpm_ctrl and the core model are compiled first.
`timescale 1ns/1ns
module chip_mode_power_mode_control_tb_top;
  import cmpm_pkg::*;
  // ****************************************************************
  // Signals and model state
  // ****************************************************************
  logic clk_sys_in = 1'b0, arst_n_in = 1'b0, mode_select_strap_in = 1'b0;
  logic secure_in = 1'b0, mode_wr_in = 1'b0, mode_wdata_in = 1'b0;
  logic clk_cfg_wr_in = 1'b0, clk_src_sel_in = 1'b0;
  logic nonmaskable_int_request_in = 1'b0, ext_irq_in = 1'b0;
  logic int_unmasked_in = 1'b0;
  logic [5:0] pll_mult_in = 6'h00;
  logic [3:0] ps_evt_in = 4'h0, ps_en_in = 4'h0, st_evt_in = 4'h0;
  logic [3:0] st_en_in = 4'h0, freeze_en_in = 4'h0;
  logic [7:0] periph_wait_gate_in = 8'h00;
  logic [1:0] req = 2'h0;
  logic wait_instruction_in, stop_instruction_in, pstop_sel_in;
  logic mode_normal_out, mode_wr_refused_out, cpu_start_out;
  logic boot_from_rom_out, background_debug_unit_active_out;
  logic debug_enable_out, flash_dbg_block_out, clk_src_sel_out;
  logic cpu_clk_en_out, sys_clk_en_out, osc_en_out, counters_frozen_out;
  logic [15:0] fetch_vector_out;
  logic [3:0]  freeze_out, ps_clk_en_out, st_src_live_out;
  logic [5:0]  pll_mult_out, e_pll;
  logic [1:0]  pwr_state_out;
  logic [7:0]  periph_clk_en_out;
  logic        md, live, rf;
  cmpm_pwr_e   st;
  logic [47:0] last_e, prev;
  logic [47:0] q[$];
  int          mismatches = 0, check_count = 0;
  wire  [47:0] obs = {mode_wr_refused_out, mode_normal_out, pwr_state_out,
    cpu_clk_en_out, sys_clk_en_out, osc_en_out, counters_frozen_out,
    periph_clk_en_out, ps_clk_en_out, st_src_live_out, boot_from_rom_out,
    background_debug_unit_active_out, fetch_vector_out, debug_enable_out,
    flash_dbg_block_out, freeze_out};

  always #2 clk_sys_in = ~clk_sys_in;

  cmpm_ctrl u_dut (.clk_sys_in, .arst_n_in, .mode_select_strap_in,
    .secure_in, .mode_wr_in, .mode_wdata_in, .clk_cfg_wr_in, .clk_src_sel_in,
    .pll_mult_in, .wait_instruction_in, .stop_instruction_in, .pstop_sel_in,
    .nonmaskable_int_request_in, .ext_irq_in, .int_unmasked_in, .ps_evt_in,
    .ps_en_in, .st_evt_in, .st_en_in, .periph_wait_gate_in, .freeze_en_in,
    .mode_normal_out, .mode_wr_refused_out, .cpu_start_out,
    .boot_from_rom_out, .fetch_vector_out, .background_debug_unit_active_out,
    .debug_enable_out, .flash_dbg_block_out, .freeze_out, .clk_src_sel_out,
    .pll_mult_out, .pwr_state_out, .cpu_clk_en_out, .sys_clk_en_out,
    .osc_en_out, .counters_frozen_out, .periph_clk_en_out, .ps_clk_en_out,
    .st_src_live_out);

  cmpm_core_model u_core (.clk_sys_in, .pwr_state_in(pwr_state_out),
    .req_in(req), .wait_instruction_out(wait_instruction_in),
    .stop_instruction_out(stop_instruction_in),
    .pstop_sel_out(pstop_sel_in));

  // ****************************************************************
  // Expectation, notes and comparison
  // ****************************************************************
  function automatic logic [47:0] exp_obs();
    logic w;
    w = (st == PM_RUN) || (st == PM_WAIT);
    return {rf, md, st, st == PM_RUN, w, st != PM_STOP, st == PM_STOP,
      (st == PM_RUN) ? 8'hFF : ((st == PM_WAIT) ? ~periph_wait_gate_in
      : 8'h00), w ? 4'hF : ((st == PM_PSTOP) ? ps_en_in : 4'h0),
      (st == PM_STOP) ? st_en_in : 4'hF, live & ~md, live & ~md,
      (live & ~md) ? MON_ROM_ENTRY : RESET_VEC_ADDR,
      live & (~md | ~secure_in), ~live | secure_in,
      live ? (freeze_en_in & {4{~md}}) : 4'h0};
  endfunction

  task automatic tick(int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // A note is queued only when the outputs should change, so each queued
  // value lines up with exactly one observed change.
  task automatic note();
    logic [47:0] e;
    e = exp_obs();
    if (e !== last_e) q.push_back(e);
    last_e = e;
  endtask

  task automatic go(logic [1:0] r, cmpm_pwr_e s);
    req = r;
    st = s;
    note();
    tick(1);
    req = 2'h0;
    tick(2);
  endtask

  task automatic wait_run();
    int n = 0;
    while (pwr_state_out !== PM_RUN && n < 8) begin
      tick(1);
      n++;
    end
    if (n == 8) begin
      mismatches++;
      finish_test();
    end
  endtask

  task automatic wake_ev(int k, int i);
    st = PM_RUN;
    note();
    case (k)
      0: {nonmaskable_int_request_in, ext_irq_in, int_unmasked_in} =
           3'b100 >> i;
      1: ps_evt_in[i] = 1'b1;
      default: st_evt_in[i] = 1'b1;
    endcase
    tick(1);
    {nonmaskable_int_request_in, ext_irq_in, int_unmasked_in} = 3'b000;
    ps_evt_in = 4'h0;
    st_evt_in = 4'h0;
    wait_run();
  endtask

  task automatic mode_write(logic d);
    mode_wr_in = 1'b1;
    mode_wdata_in = d;
    if (d & ~md) md = 1'b1;
    else rf = 1'b1;
    note();
    tick(1);
    mode_wr_in = 1'b0;
    rf = 1'b0;
    note();
    tick(2);
  endtask

  // ****************************************************************
  // Output watcher and time limit
  // ****************************************************************
  initial begin
    tick(1);
    prev = obs;
    forever begin
      tick(1);
      if (obs !== prev) begin
        if (q.size() == 0) check("outputs", obs, prev);
        else check("outputs", obs, q.pop_front());
        prev = obs;
      end
    end
  end

  initial begin
    #200000;
    mismatches++;
    finish_test();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    void'($urandom(32'hD8B4));
    md = 1'b1;
    live = 1'b0;
    rf = 1'b0;
    st = PM_RUN;
    last_e = exp_obs();
    tick(20);
    check("cpu_start", cpu_start_out, 0);
    arst_n_in = 1'b1;
    live = 1'b1;
    md = 1'b0;
    note();
    tick(2);
    check("cpu_start", cpu_start_out, 1);
    freeze_en_in = 4'($urandom);
    note();
    tick(2);
    freeze_en_in = 4'h0;
    note();
    tick(2);
    secure_in = 1'b1;
    note();
    tick(2);
    secure_in = 1'b0;
    note();
    tick(2);
    mode_write(1'b0);
    mode_write(1'b1);
    mode_write(1'b0);
    mode_write(1'b1);
    secure_in = 1'b1;
    note();
    tick(2);
    e_pll = 6'($urandom);
    {clk_cfg_wr_in, clk_src_sel_in, pll_mult_in} = {2'b11, e_pll};
    tick(1);
    clk_cfg_wr_in = 1'b0;
    tick(1);
    check("pll_mult", pll_mult_out, e_pll);
    check("clk_src", clk_src_sel_out, 1);
    for (int i = 0; i < 3; i++) begin
      go(2'h1, PM_WAIT);
      periph_wait_gate_in = 8'($urandom);
      note();
      {clk_cfg_wr_in, pll_mult_in} = {1'b1, ~e_pll};
      tick(1);
      clk_cfg_wr_in = 1'b0;
      tick(1);
      check("pll_mult", pll_mult_out, e_pll);
      wake_ev(0, i);
    end
    for (int i = 0; i < 4; i++) begin
      ps_en_in = 4'($urandom) | (4'h1 << i);
      go(2'h2, PM_PSTOP);
      wake_ev(1, i);
    end
    for (int i = 0; i < 4; i++) begin
      st_en_in = 4'($urandom) & ~(4'h1 << i);
      go(2'h3, PM_STOP);
      st_evt_in[i] = 1'b1;
      nonmaskable_int_request_in = 1'b1;
      tick(1);
      {st_evt_in, nonmaskable_int_request_in} = 5'h00;
      tick(4);
      check("pwr_state", pwr_state_out, PM_STOP);
      st_en_in[i] = 1'b1;
      note();
      tick(1);
      wake_ev(2, i);
    end
    go(2'h1, PM_WAIT);
    st = PM_RUN;
    md = 1'b1;
    live = 1'b0;
    note();
    arst_n_in = 1'b0;
    mode_select_strap_in = 1'b1;
    tick(3);
    arst_n_in = 1'b1;
    live = 1'b1;
    note();
    tick(3);
    check("cpu_start", cpu_start_out, 1);
    for (int n = 0; n < 10 && q.size() != 0; n++) tick(1);
    check("queue_left", q.size(), 0);
    finish_test();
  end
endmodule

// File: testbench/cmpm_core_model.sv
// Core model: issues the wait and stop instructions on bench request.
// Assumes requests change at the falling edge of clk_sys_in.
`timescale 1ns/1ns
module cmpm_core_model
  import cmpm_pkg::*;
(
  // Clock and power state seen by the core
  input  wire logic       clk_sys_in,
  input  wire logic [1:0] pwr_state_in,
  // Bench request: 1 wait, 2 pseudo-stop, 3 stop
  input  wire logic [1:0] req_in,
  // Instruction pulses
  output logic            wait_instruction_out,
  output logic            stop_instruction_out,
  output logic            pstop_sel_out
);
  logic [1:0] req_reg = 2'h0;
  logic       run;

  // A real core executes nothing while halted, so it never issues an
  // instruction outside run.
  assign run = (pwr_state_in == PM_RUN);

  always @(posedge clk_sys_in) req_reg <= req_in;

  always @(negedge clk_sys_in) begin
    wait_instruction_out <= run && (req_reg == 2'h1);
    stop_instruction_out <= run && req_reg[1];
    pstop_sel_out        <= (req_reg == 2'h2);
  end
endmodule
